// ==== verilog/dma_watch_regs.v ====
// What this block does
// R1 - Nonzero count field arms the receive watchdog.
// R2 - Bus state bit zero shows master busy.
// R3 - Current transmit descriptor pointer, read only.
// R4 - Current receive descriptor pointer, read only.
// R5 - Current transmit buffer pointer, read only.
// R6 - Rx done flag bit six, gated by enables.
// R7 - Watchdog timeout bit nine, abnormal-gated interrupt.
// R8 - Deferred frame starts count; expiry sets flag.
//
// Purpose: Watchdog and observation registers of an Ethernet DMA, AXI4-Lite slave.
// Assumes: Descriptor engine drives the pointer and event inputs on clk_i.
// Notes: Pointers are sampled into flip-flops so reads see a stable word.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "dma_watch_defines.vh"
module dma_watch_regs (
	input wire clk_i,
	input wire rst_i,
	// AXI4-Lite write address channel.
	input wire [31:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	// AXI4-Lite write data channel.
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	// AXI4-Lite write response channel.
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	// AXI4-Lite read address channel.
	input wire [31:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	// AXI4-Lite read data channel.
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// DMA engine side.
	input wire bus_master_busy_i,
	input wire [31:0] tx_descriptor_address_i,
	input wire [31:0] rx_descriptor_address_i,
	input wire [31:0] tx_buffer_address_i,
	input wire rx_frame_done_i,
	input wire rx_done_deferred_i,
	output wire rx_done_irq_o,
	output wire rx_wdog_irq_o,
	output wire irq_o
);
	// Write path state: address and data may arrive in either order.
	reg aw_have_q;
	reg w_have_q;
	reg [15:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	// Read path state.
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	// Software registers.
	reg [7:0] watchdog_count_field_q;
	reg [31:0] irq_enable_q;
	reg [`EVT_W-1:0] evt_mask_q;
	// Hardware state.
	reg rx_done_flag_q;
	reg rx_wdog_flag_q;
	reg [`EVT_W-1:0] evt_status_q;
	reg bus_busy_q;
	reg [31:0] tx_desc_q;
	reg [31:0] rx_desc_q;
	reg [31:0] tx_buf_q;
	// Watchdog tick counter, whole ticks since the period began.
	// Eight bits suffice, as expiry comes by tick 255 at the latest.
	reg [7:0] wdog_cnt_q;

	// Watchdog state machine, one-hot.
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_COUNT = 3'b010;
	localparam [2:0] ST_FIRE = 3'b100;
	reg [2:0] st_q;
	reg [2:0] st_d;

	// Bus strobes: a write commits, a read address is taken.
	wire wr_fire;
	wire rd_fire;
	// Watchdog tick, period start and expiry strobes.
	wire tick;
	wire start_count;
	wire wdog_expire;
	wire [15:0] rd_addr;

	// Merge byte lanes of a write into an old word.
	function [31:0] merge_bytes;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] strb;
		integer i;
		begin
			merge_bytes = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge_bytes[i*8 +: 8] = new_v[i*8 +: 8];
				end
			end
		end
	endfunction

	// Tells whether an address names a mapped register.
	function is_mapped;
		input [15:0] a;
		begin
			case (a)
				`OFS_WDOG_COUNT, `OFS_BUS_STATE, `OFS_TX_DESC, `OFS_RX_DESC,
				`OFS_TX_BUF, `OFS_DMA_STATUS, `OFS_IRQ_ENABLE, `OFS_EVT_STATUS,
				`OFS_EVT_MASK: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// Channels accept as soon as their holding slot is free and no response waits.
	assign s_axi_awready_o = !aw_have_q && !bvalid_q;
	assign s_axi_wready_o = !w_have_q && !bvalid_q;
	assign s_axi_arready_o = !rvalid_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign rd_fire = s_axi_arvalid_i && !rvalid_q;
	assign rd_addr = s_axi_araddr_i[15:0];

	// Capture address and data separately; the write commits when both are held.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 16'h0000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
		end else begin
			// Address taken; it waits in its slot for the data.
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_i[15:0];
			end
			// Data taken; they wait in their slot for the address.
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				// Unmapped addresses answer with a slave error.
				bresp_q <= is_mapped(aw_addr_q) ? 2'b00 : 2'b10;
			end else if (bvalid_q && s_axi_bready_i) begin
				// The master took the response; new requests may enter.
				bvalid_q <= 1'b0;
			end
		end
	end

	// Software-writable registers; read-only addresses ignore write data.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			watchdog_count_field_q <= 8'h00;
			irq_enable_q <= `RST_WORD;
			evt_mask_q <= {`EVT_W{1'b0}};
		end else if (wr_fire) begin
			case (aw_addr_q)
				`OFS_WDOG_COUNT: begin
					if (w_strb_q[0]) begin
						watchdog_count_field_q <= w_data_q[7:0]; // [R1]
					end
				end
				`OFS_IRQ_ENABLE: begin
					irq_enable_q <= merge_bytes(irq_enable_q, w_data_q, w_strb_q);
				end
				`OFS_EVT_MASK: begin
					if (w_strb_q[0]) begin
						evt_mask_q <= w_data_q[`EVT_W-1:0];
					end
				end
				// Read-only and unmapped addresses change no register here.
				default: begin
					irq_enable_q <= irq_enable_q;
				end
			endcase
		end
	end

	// Pointers and busy status come from engine logic on this clock; sampled once.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_busy_q <= 1'b0;
			tx_desc_q <= `RST_WORD;
			rx_desc_q <= `RST_WORD;
			tx_buf_q <= `RST_WORD;
		end else begin
			// One stage only, so a read shows the value of the cycle before.
			bus_busy_q <= bus_master_busy_i; // [R2]
			tx_desc_q <= tx_descriptor_address_i; // [R3]
			rx_desc_q <= rx_descriptor_address_i; // [R4]
			tx_buf_q <= tx_buffer_address_i; // [R5]
		end
	end

	// Tick generator restarts whenever a new watchdog period begins.
	tick_divider u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(start_count),
		.tick_o(tick)
	);

	// A frame done with its flag deferred starts the count when armed.
	assign start_count = rx_frame_done_i && rx_done_deferred_i &&
		(watchdog_count_field_q != 8'h00) && (st_q == ST_IDLE); // [R1] [R8]
	assign wdog_expire = (st_q == ST_COUNT) && tick &&
		(wdog_cnt_q + 8'h01 >= watchdog_count_field_q); // [R8]

	// Next-state logic of the watchdog.
	always @* begin
		case (st_q)
			// Waits for a deferred frame while the count field is nonzero.
			ST_IDLE: st_d = start_count ? ST_COUNT : ST_IDLE;
			// Clearing the count field mid-period disarms the watchdog.
			ST_COUNT: begin
				if (watchdog_count_field_q == 8'h00) begin
					st_d = ST_IDLE; // [R1]
				end else begin
					st_d = wdog_expire ? ST_FIRE : ST_COUNT;
				end
			end
			// One cycle in which the flags are set, then back to waiting.
			ST_FIRE: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	// State and tick counter registers.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			wdog_cnt_q <= 8'h00;
		end else begin
			st_q <= st_d;
			if (start_count) begin
				// A new period always counts from tick zero.
				wdog_cnt_q <= 8'h00;
			end else if (st_q == ST_COUNT && tick) begin
				// One more whole tick has passed in this period.
				wdog_cnt_q <= wdog_cnt_q + 8'h01;
			end
		end
	end

	// Status flags: hardware set wins over a write-one clear in the same cycle.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_done_flag_q <= 1'b0;
			rx_wdog_flag_q <= 1'b0;
		end else begin
			// Software clears either flag by writing a one to its bit.
			if (wr_fire && aw_addr_q == `OFS_DMA_STATUS && w_data_q[`BIT_RX_DONE]) begin
				rx_done_flag_q <= 1'b0;
			end
			if (wr_fire && aw_addr_q == `OFS_DMA_STATUS && w_data_q[`BIT_RX_WDOG]) begin
				rx_wdog_flag_q <= 1'b0;
			end
			// Immediate frames set the flag now; deferred ones wait for expiry.
			if ((rx_frame_done_i && !rx_done_deferred_i) || st_q == ST_FIRE) begin
				rx_done_flag_q <= 1'b1; // [R6] [R8]
			end
			// Only an expiry records the timeout; immediate frames never do.
			if (st_q == ST_FIRE) begin
				rx_wdog_flag_q <= 1'b1; // [R7]
			end
		end
	end

	// Gated interrupts: normal summary for rx done, abnormal summary for timeout.
	assign rx_done_irq_o = rx_done_flag_q && irq_enable_q[`BIT_RX_DONE] &&
		irq_enable_q[`BIT_NORM_SUM]; // [R6]
	assign rx_wdog_irq_o = rx_wdog_flag_q && irq_enable_q[`BIT_RX_WDOG] &&
		irq_enable_q[`BIT_ABN_SUM]; // [R7]

	// Sticky local events, cleared by reading the status word; a new event wins.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			evt_status_q <= {`EVT_W{1'b0}};
		end else begin
			// Reading the word clears it; an event in that cycle still wins.
			if (rd_fire && rd_addr == `OFS_EVT_STATUS) begin
				evt_status_q <= {`EVT_W{1'b0}};
			end
			// Each gated interrupt line records itself as a local event.
			if (rx_done_irq_o) begin
				evt_status_q[0] <= 1'b1;
			end
			if (rx_wdog_irq_o) begin
				evt_status_q[1] <= 1'b1;
			end
		end
	end

	// One level output while any unmasked event bit is set.
	assign irq_o = |(evt_status_q & evt_mask_q);

	// Read data path: one register stage, answer one cycle after the address.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= `RST_WORD;
			rresp_q <= 2'b00;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rresp_q <= is_mapped(rd_addr) ? 2'b00 : 2'b10;
			case (rd_addr)
				`OFS_WDOG_COUNT: rdata_q <= {24'h000000, watchdog_count_field_q};
				`OFS_BUS_STATE: rdata_q <= {31'h0, bus_busy_q}; // [R2]
				`OFS_TX_DESC: rdata_q <= tx_desc_q; // [R3]
				`OFS_RX_DESC: rdata_q <= rx_desc_q; // [R4]
				`OFS_TX_BUF: rdata_q <= tx_buf_q; // [R5]
				// Timeout flag in bit nine, receive done flag in bit six.
				`OFS_DMA_STATUS: rdata_q <= {22'h0, rx_wdog_flag_q, 2'b00,
					rx_done_flag_q, 6'h00};
				`OFS_IRQ_ENABLE: rdata_q <= irq_enable_q;
				`OFS_EVT_STATUS: rdata_q <= {30'h0, evt_status_q};
				`OFS_EVT_MASK: rdata_q <= {30'h0, evt_mask_q};
				// Unmapped reads return zero along with the slave error.
				default: rdata_q <= 32'h00000000;
			endcase
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule // dma_watch_regs

// ==== verilog/dma_watch_defines.vh ====
// Purpose: Offsets, field positions, reset values and timing counts of the watchdog slice.
// Assumes: Byte addresses on a 32-bit register bus, one aligned word per register.
// Notes: Definitions only.
`ifndef DMA_WATCH_DEFINES_VH
`define DMA_WATCH_DEFINES_VH
// Register byte addresses (low 16 bits of the bus address).
`define OFS_WDOG_COUNT 16'h1024
`define OFS_BUS_STATE 16'h102c
`define OFS_TX_DESC 16'h1048
`define OFS_RX_DESC 16'h104c
`define OFS_TX_BUF 16'h1050
`define OFS_DMA_STATUS 16'h1014
`define OFS_IRQ_ENABLE 16'h101c
`define OFS_EVT_STATUS 16'h1060
`define OFS_EVT_MASK 16'h1064
// Field positions.
`define BIT_RX_DONE 6
`define BIT_RX_WDOG 9
`define BIT_ABN_SUM 15
`define BIT_NORM_SUM 16
`define BIT_BUS_BUSY 0
// Reset values.
`define RST_WORD 32'h00000000
// The watchdog counts in ticks of one more than this many system clocks.
`define WDOG_TICK_CYCLES 8'hff
// Number of local event bits.
`define EVT_W 2
`endif

// ==== verilog/tick_divider.v ====
// Purpose: Makes a one-cycle enable pulse every WDOG_TICK_CYCLES+1 clocks.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Restart realigns the tick phase to the moment of arming.
`timescale 1ns/10ps
`include "dma_watch_defines.vh"
module tick_divider (
	input wire clk_i,
	input wire rst_i,
	input wire restart_i,
	output wire tick_o
);
	// Free-running down counter.
	reg [7:0] cnt_q;

	// Reload on restart or on reaching zero, so each tick is one cycle wide.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 8'h00;
		end else if (restart_i || cnt_q == 8'h00) begin
			cnt_q <= `WDOG_TICK_CYCLES;
		end else begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	assign tick_o = (cnt_q == 8'h00) && !restart_i;
endmodule // tick_divider

// ==== verification/dma_watch_checker.sv ====
// Purpose: Port assertions for the watchdog and pointer slice.
// Assumes: One clock; rst_i is asynchronous and active high.
// Notes: Read data is compared with the inputs two edges back.
`timescale 1ns/10ps
`include "dma_watch_defines.vh"
module dma_watch_checker (
	input wire clk_i,
	input wire rst_i,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	input wire [31:0] s_axi_araddr_i,
	input wire [31:0] s_axi_rdata_o,
	input wire bus_master_busy_i,
	input wire [31:0] tx_descriptor_address_i,
	input wire [31:0] rx_descriptor_address_i,
	input wire [31:0] tx_buffer_address_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A read taken at address a, with reset well behind it.
	sequence s_rd(a);
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[15:0] == a && !$past(rst_i, 2);
	endsequence
	// The word returned one cycle after that read.
	property p_ret(a, v);
		s_rd(a) |=> s_axi_rdata_o == v;
	endproperty
	a_busy_read: assert property (p_ret(`OFS_BUS_STATE, {31'h0, $past(bus_master_busy_i, 2)}))
		else $error("busy bit read wrong");
	a_txd_read: assert property (p_ret(`OFS_TX_DESC, $past(tx_descriptor_address_i, 2)))
		else $error("tx descriptor pointer read wrong");
	a_rxd_read: assert property (p_ret(`OFS_RX_DESC, $past(rx_descriptor_address_i, 2)))
		else $error("rx descriptor pointer read wrong");
	a_txb_read: assert property (p_ret(`OFS_TX_BUF, $past(tx_buffer_address_i, 2)))
		else $error("tx buffer pointer read wrong");
	a_count_upper: assert property (s_rd(`OFS_WDOG_COUNT) |=> s_axi_rdata_o[31:8] == 24'h0)
		else $error("count word upper bits not zero");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o))
		else $error("read data changed while stalled");
	a_read_reopen: assert property (s_axi_rvalid_o && s_axi_rready_i |=> s_axi_arready_o)
		else $error("read channel not reopened after answer");
endmodule // dma_watch_checker
bind dma_watch_regs dma_watch_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_rdata_o(s_axi_rdata_o),
	.bus_master_busy_i(bus_master_busy_i), .tx_descriptor_address_i(tx_descriptor_address_i),
	.rx_descriptor_address_i(rx_descriptor_address_i), .tx_buffer_address_i(tx_buffer_address_i));

// ==== verification/dma_engine_model.sv ====
// Purpose: Stand-in for the descriptor engine that feeds the slice.
// Assumes: Same clock as the slice.
// Notes: Pointers move at random while busy; the defer line is noise outside frames.
`timescale 1ns/10ps
module dma_engine_model (
	input wire clk_i,
	input wire rst_i,
	input wire frame_i,
	input wire defer_i,
	output reg busy_o,
	output reg [31:0] txd_o,
	output reg [31:0] rxd_o,
	output reg [31:0] txb_o,
	output reg done_o,
	output reg deferred_o
);
	integer seed = 32'ha718; // Own variable with a fixed start, so runs repeat.
	reg [31:0] rnd;
	// Busy comes and goes like a master with bursts and gaps.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{busy_o, txd_o, rxd_o, txb_o, done_o, deferred_o} <= 99'h0;
			rnd <= 32'h0;
		end else begin
			rnd <= $random(seed);
			busy_o <= rnd[0];
			if (busy_o) begin
				txd_o <= $random(seed);
				rxd_o <= $random(seed);
				txb_o <= $random(seed);
			end
			done_o <= frame_i;
			deferred_o <= frame_i ? defer_i : rnd[1];
		end
	end
endmodule // dma_engine_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the watchdog and pointer slice.
// Assumes: Engine model on the far side, seeded random stimulus.
// Notes: Reads stall rready one cycle so held answers get exercised.
`timescale 1ns/10ps
`include "dma_watch_defines.vh"
module tb;
	reg clk_i = 1'b0, rst_i = 1'b1, hold_q = 1'b1, fr = 1'b0, df = 1'b0;
	reg awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	reg [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, d, v;
	reg [1:0] rs, bs;
	reg [3:0] sb = 4'hf, wst = 4'hf;
	wire awr, wrdy, bv, arr, rv, rdone, rwdog, irq, busy, fd, fq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata, txd, rxd, txb;
	integer seed = 32'ha718, err_total = 0, tests_run = 0, i, n, cnt;
	localparam [79:0] ADRS = {`OFS_WDOG_COUNT, `OFS_BUS_STATE, `OFS_TX_DESC, `OFS_RX_DESC,
		`OFS_TX_BUF};
	localparam integer TICK = `WDOG_TICK_CYCLES + 1;
	initial forever #2.5 clk_i = ~clk_i;
	dma_watch_regs u_dma_watch_regs (.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(wst), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
		.bus_master_busy_i(busy), .tx_descriptor_address_i(txd), .rx_descriptor_address_i(rxd),
		.tx_buffer_address_i(txb), .rx_frame_done_i(fd), .rx_done_deferred_i(fq),
		.rx_done_irq_o(rdone), .rx_wdog_irq_o(rwdog), .irq_o(irq));
	dma_engine_model u_dma_engine_model (.clk_i(clk_i), .rst_i(rst_i | hold_q), .frame_i(fr),
		.defer_i(df), .busy_o(busy), .txd_o(txd), .rxd_o(rxd), .txb_o(txb), .done_o(fd),
		.deferred_o(fq));
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("mismatch %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", tests_run, err_total);
			if (err_total == 0 && tests_run > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask
	// Bounds every bus wait; a hang counts as a mismatch.
	task step;
		begin
			n = n + 1;
			if (n > 60) begin
				err_total = err_total + 1;
				test_done;
			end
		end
	endtask
	// Both write channels offered together, each released once taken.
	task wr(input [15:0] a, input [31:0] x);
		reg ta, tw, tk;
		begin
			@(posedge clk_i);
			awa <= {16'h0, a};
			wd <= x;
			wst <= sb;
			awv <= 1'b1;
			wv <= 1'b1;
			br <= 1'b1;
			n = 0;
			tk = 1'b0;
			while (!tk) begin
				@(negedge clk_i);
				ta = awr;
				tw = wrdy;
				tk = bv;
				bs = bresp;
				@(posedge clk_i);
				if (ta) awv <= 1'b0;
				if (tw) wv <= 1'b0;
				step;
			end
			br <= 1'b0;
			#1;
		end
	endtask
	// Read with rready raised a cycle after rvalid shows.
	task rd(input [15:0] a);
		reg ta, tk;
		begin
			@(posedge clk_i);
			ara <= {16'h0, a};
			arv <= 1'b1;
			n = 0;
			tk = 1'b0;
			while (!tk) begin
				@(negedge clk_i);
				ta = arr;
				tk = rv && rr;
				d = rdata;
				rs = rresp;
				@(posedge clk_i);
				if (ta) arv <= 1'b0;
				rr <= rv && !tk;
				step;
			end
			#1;
		end
	endtask
	task frame(input dfr);
		begin
			@(posedge clk_i);
			fr <= 1'b1;
			df <= dfr;
			@(posedge clk_i);
			fr <= 1'b0;
			// The engine passes the frame on one edge later, the flags follow.
			repeat (2) @(posedge clk_i);
			#1;
		end
	endtask
	// Expiry lands the programmed number of ticks after the frame, give or take a few.
	function wd_ok(input integer nt, input integer lat);
		wd_ok = lat >= nt * TICK - 4 && lat <= nt * TICK + 4;
	endfunction
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 5; i = i + 1) begin
			rd(ADRS[i * 16 +: 16]);
			chk("reset", d, `RST_WORD);
		end
		wr(`OFS_TX_DESC, 32'hffffffff);
		chk("wr_okay", {30'h0, bs}, 32'h0);
		rd(`OFS_TX_DESC);
		chk("ro_ptr", d, 32'h0);
		rd(16'h1028);
		chk("unmapped", {d[29:0], rs}, 32'h2);
		wr(16'h1028, 32'h0);
		chk("wr_unmapped", {30'h0, bs}, 32'h2);
		for (i = 0; i < 6; i = i + 1) begin
			v = (i == 0) ? 32'hffffffff : $random(seed);
			wr(`OFS_WDOG_COUNT, v);
			rd(`OFS_WDOG_COUNT);
			chk("count", d, {24'h0, v[7:0]});
		end
		sb = 4'he;
		wr(`OFS_WDOG_COUNT, 32'h0);
		sb = 4'hf;
		rd(`OFS_WDOG_COUNT);
		chk("count_lane", d, {24'h0, v[7:0]});
		hold_q <= 1'b0;
		for (i = 0; i < 24; i = i + 1) begin
			rd(ADRS[({$random(seed)} % 4) * 16 +: 16]);
		end
		wr(`OFS_EVT_MASK, 32'h0);
		wr(`OFS_IRQ_ENABLE, 32'h00018240);
		frame(1'b0);
		chk("rx_done", rdone, 1);
		chk("masked", irq, 0);
		wr(`OFS_EVT_MASK, 32'h3);
		chk("unmasked", irq, 1);
		wr(`OFS_IRQ_ENABLE, 32'h00000240);
		chk("no_summary", rdone, 0);
		wr(`OFS_DMA_STATUS, 32'h00000240);
		wr(`OFS_IRQ_ENABLE, 32'h00018240);
		rd(`OFS_EVT_STATUS);
		chk("evt", d, 32'h1);
		rd(`OFS_EVT_STATUS);
		chk("evt_clr", {d[30:0], irq}, 32'h0);
		cnt = 1 + {$random(seed)} % 3;
		wr(`OFS_WDOG_COUNT, cnt);
		frame(1'b1);
		for (n = 0; rwdog !== 1'b1 && n < 1200; n = n + 1) begin
			@(posedge clk_i);
			#1;
		end
		chk("wdog_time", wd_ok(cnt, n), 1);
		chk("wdog_flag", rdone, 1);
		wr(`OFS_IRQ_ENABLE, 32'h00010240);
		chk("no_abnormal", rwdog, 0);
		wr(`OFS_IRQ_ENABLE, 32'h00018240);
		chk("abnormal", rwdog, 1);
		wr(`OFS_DMA_STATUS, 32'h00000240);
		wr(`OFS_WDOG_COUNT, 32'h0);
		frame(1'b1);
		repeat (800) @(posedge clk_i);
		#1;
		chk("disarmed", {rwdog, rdone}, 0);
		test_done;
	end
endmodule // tb
